// [rtl/mft_irq_dma.sv]
// interrupt grouping, overrun, and two-channel dma request logic
`timescale 1ns/1ps
`include "mft_defs.svh"
module mft_irq_dma #(
   parameter int CNT_W = 16
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clk_en,
   input  wire logic [3:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output      logic [7:0]            reg_rdata,
   input  wire logic                  compare_zero_event,
   input  wire logic                  compare_one_event,
   input  wire logic                  capture_zero_event,
   input  wire logic                  capture_one_event,
   input  wire logic                  over_underflow_event,
   output      mft_pkg::mft_irq_t     irq_out,
   input  wire logic                  irq_ack,
   output      mft_pkg::mft_dma_req_t dma_req,
   input  wire logic                  dma_byte_done
);
   import mft_pkg::*;

   logic [7:0]       vector_base_register_q;
   logic [7:0]       interrupt_dma_mask_register_q;
   logic [7:0]       timer_flag_register_q;
   logic [7:0]       dma_counter_pointer_q;
   logic [7:0]       dma_address_pointer_q;
   logic [7:0]       dma_control_register_q;
   logic [CNT_W-1:0] cnt_cmp_q;
   logic [CNT_W-1:0] cnt_cap_q;
   logic [4:0]       pend_q;   // {ouf, cap1, cap0, cmp1, cmp0}
   logic [7:0]       rdata_q;
   mft_state_t       state_q;
   logic             serve_cap_q;
   logic             req_cmp_q;
   logic             req_cap_q;

   // derived control
   logic swap_enable;
   logic transfer_type_select;
   logic capture_dma_mask;
   logic compare_dma_mask;
   logic wr_mask;
   logic wr_flag;
   logic wr_pend;
   logic eob_cmp_hw;
   logic eob_cap_hw;
   logic last_cmp;
   logic last_cap;
   logic sw_eob_cmp;
   logic sw_eob_cap;
   logic dma_active;

   assign swap_enable          = dma_control_register_q[`MFT_C_SWAP];
   assign transfer_type_select = dma_counter_pointer_q[`MFT_P_XSEL];
   assign capture_dma_mask     = interrupt_dma_mask_register_q[`MFT_M_CAP_DMA];
   assign compare_dma_mask     = interrupt_dma_mask_register_q[`MFT_M_CMP_DMA];
   assign wr_mask              = reg_wr && (reg_addr == `MFT_A_MASK);
   assign wr_flag              = reg_wr && (reg_addr == `MFT_A_FLAG);
   assign wr_pend              = reg_wr && (reg_addr == `MFT_A_PEND);
   assign dma_active           = (state_q != MFT_IDLE) || req_cmp_q || req_cap_q;

   // a counter of one means this word finishes the table
   assign last_cmp   = (cnt_cmp_q == CNT_W'(1)) || (cnt_cmp_q == '0);
   assign last_cap   = (cnt_cap_q == CNT_W'(1)) || (cnt_cap_q == '0);
   assign eob_cmp_hw = (state_q == MFT_BYTE2) && dma_byte_done && !serve_cap_q && last_cmp;
   assign eob_cap_hw = (state_q == MFT_BYTE2) && dma_byte_done && serve_cap_q && last_cap;
   // test write emulates end of block
   assign sw_eob_cmp = wr_flag && reg_wdata[`MFT_F_EOB_CMP] && swap_enable
                       && !timer_flag_register_q[`MFT_F_EOB_CMP];
   assign sw_eob_cap = wr_flag && reg_wdata[`MFT_F_EOB_CAP] && swap_enable
                       && !timer_flag_register_q[`MFT_F_EOB_CAP];

   // software registers without hardware side effects
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         vector_base_register_q <= `MFT_RST8;
         dma_control_register_q <= `MFT_RST8;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == `MFT_A_VECTOR) vector_base_register_q <= reg_wdata;
         if (reg_addr == `MFT_A_DCTL) dma_control_register_q <= reg_wdata;
      end
   end

   // mask register; protection clears dma mask on hardware end of block while flag still set
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         interrupt_dma_mask_register_q <= `MFT_RST8;
      end else if (clk_en) begin
         if (wr_mask) interrupt_dma_mask_register_q <= reg_wdata;
         // second end of block disables dma
         if (eob_cmp_hw && timer_flag_register_q[`MFT_F_EOB_CMP])
            interrupt_dma_mask_register_q[`MFT_M_CMP_DMA] <= 1'b0;
         if (eob_cap_hw && timer_flag_register_q[`MFT_F_EOB_CAP])
            interrupt_dma_mask_register_q[`MFT_M_CAP_DMA] <= 1'b0;
      end
   end

   // pointer registers; swap toggles the channel's own bit 2
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dma_counter_pointer_q <= `MFT_RST8;
         dma_address_pointer_q <= `MFT_RST8;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `MFT_A_DMA_COUNTER_POINTER) dma_counter_pointer_q <= reg_wdata;
         if (reg_wr && reg_addr == `MFT_A_DMA_ADDRESS_POINTER) dma_address_pointer_q <= reg_wdata;
         if (swap_enable && (eob_cmp_hw || sw_eob_cmp))
            dma_counter_pointer_q[`MFT_P_TOGGLE] <= ~dma_counter_pointer_q[`MFT_P_TOGGLE];
         if (swap_enable && (eob_cap_hw || sw_eob_cap))
            dma_address_pointer_q[`MFT_P_TOGGLE] <= ~dma_address_pointer_q[`MFT_P_TOGGLE];
      end
   end

   // transaction counters; loaded by software, count words down
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_cmp_q <= '0;
         cnt_cap_q <= '0;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `MFT_A_CNT_CMP) cnt_cmp_q <= CNT_W'(reg_wdata);
         if (reg_wr && reg_addr == `MFT_A_CNT_CAP) cnt_cap_q <= CNT_W'(reg_wdata);
         if (state_q == MFT_BYTE2 && dma_byte_done) begin
            if (!serve_cap_q) cnt_cmp_q <= last_cmp ? '0 : cnt_cmp_q - CNT_W'(1);
            else cnt_cap_q <= last_cap ? '0 : cnt_cap_q - CNT_W'(1);
         end
      end
   end

   // flag register: overrun and end of block, set wins over clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         timer_flag_register_q <= `MFT_RST8;
      end else if (clk_en) begin
         if (wr_flag) timer_flag_register_q <= reg_wdata & 8'h0F;
         if (compare_zero_event && pend_q[0])
            timer_flag_register_q[`MFT_F_OVR_CMP] <= 1'b1;
         if (capture_zero_event && pend_q[2])
            timer_flag_register_q[`MFT_F_OVR_CAP] <= 1'b1;
         if (eob_cmp_hw) timer_flag_register_q[`MFT_F_EOB_CMP] <= 1'b1;
         if (eob_cap_hw) timer_flag_register_q[`MFT_F_EOB_CAP] <= 1'b1;
      end
   end

   // pending bits; software clears by writing ones
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pend_q <= 5'h00;
      end else if (clk_en) begin
         pend_q <= pend_q & ~(wr_pend ? reg_wdata[4:0] : 5'h00);
         if (irq_ack && irq_out.valid) begin
            case (irq_out.vector[2:0])
               `MFT_G_OUF: pend_q[4] <= 1'b0;
               default:    ;
            endcase
         end
         // dma mode uses end of block
         if (compare_dma_mask ? (eob_cmp_hw || sw_eob_cmp) : compare_zero_event)
            pend_q[0] <= 1'b1;
         if (compare_one_event) pend_q[1] <= 1'b1;
         if (capture_dma_mask ? (eob_cap_hw || sw_eob_cap) : capture_zero_event)
            pend_q[2] <= 1'b1;
         if (capture_one_event) pend_q[3] <= 1'b1;
         if (over_underflow_event) pend_q[4] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         req_cmp_q <= 1'b0;
         req_cap_q <= 1'b0;
      end else if (clk_en) begin
         if (state_q == MFT_IDLE && req_cap_q) req_cap_q <= 1'b0;
         else if (state_q == MFT_IDLE && req_cmp_q) req_cmp_q <= 1'b0;
         if (compare_zero_event && compare_dma_mask) req_cmp_q <= 1'b1;
         if (capture_zero_event && capture_dma_mask) req_cap_q <= 1'b1;
      end
   end

   // word transfer sequencer: two bytes per request
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q     <= MFT_IDLE;
         serve_cap_q <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            MFT_IDLE: begin
               if (req_cap_q) begin
                  state_q     <= MFT_BYTE1;
                  serve_cap_q <= 1'b1;
               end else if (req_cmp_q) begin
                  state_q     <= MFT_BYTE1;
                  serve_cap_q <= 1'b0;
               end
            end
            MFT_BYTE1: if (dma_byte_done) state_q <= MFT_BYTE2;
            MFT_BYTE2: if (dma_byte_done) state_q <= MFT_IDLE;
            default:   state_q <= MFT_IDLE;
         endcase
      end
   end

   // dma request output, formed from registered state
   always_comb begin
      logic [2:0] grp;
      grp = serve_cap_q ? `MFT_G_CAP : `MFT_G_CMP;
      dma_req             = '0;
      dma_req.valid       = (state_q != MFT_IDLE);
      dma_req.to_compare  = !serve_cap_q;
      dma_req.second_byte = (state_q == MFT_BYTE2);
      dma_req.prio_level  = (state_q == MFT_BYTE2) ? `MFT_PRIO_TOP : grp;
      dma_req.reg_to_reg  = transfer_type_select;
      dma_req.counter_addr = {dma_counter_pointer_q[7:3], 3'h0};
      dma_req.address_addr = {dma_address_pointer_q[7:3], 3'h0};
      dma_req.counter_addr[`MFT_P_TOGGLE] = serve_cap_q ?
         dma_address_pointer_q[`MFT_P_TOGGLE] : dma_counter_pointer_q[`MFT_P_TOGGLE];
      dma_req.address_addr[`MFT_P_TOGGLE] = dma_req.counter_addr[`MFT_P_TOGGLE];
      dma_req.counter_addr[1] = !serve_cap_q;
      dma_req.address_addr[1] = !serve_cap_q;
      if (transfer_type_select) begin
         dma_req.address_addr = '0;
         dma_req.counter_addr[1] = !serve_cap_q;
      end
   end

   // interrupt arbitration over the three groups
   always_comb begin
      logic [7:0] m;
      logic       ouf_on;
      logic       cmp_on;
      logic       cap_on;
      m = interrupt_dma_mask_register_q;
      ouf_on = m[`MFT_M_GLOBAL] && pend_q[4] && m[`MFT_M_OUF];
      cmp_on = m[`MFT_M_GLOBAL] && ((pend_q[0] && m[`MFT_M_CMP_IRQ]) || (pend_q[1] && m[`MFT_M_CMP1]));
      cap_on = m[`MFT_M_GLOBAL] && ((pend_q[2] && m[`MFT_M_CAP_IRQ]) || (pend_q[3] && m[`MFT_M_CAP1]));
      if (dma_active) begin
         cmp_on = cmp_on && !pend_q[0];
         cap_on = cap_on && !pend_q[2];
      end
      irq_out = '0;
      if (ouf_on) begin
         irq_out.valid  = 1'b1;
         irq_out.vector = {vector_base_register_q[7:3], `MFT_G_OUF};
      end else if (cap_on) begin
         irq_out.valid  = 1'b1;
         irq_out.vector = {vector_base_register_q[7:3], `MFT_G_CAP};
      end else if (cmp_on) begin
         irq_out.valid  = 1'b1;
         irq_out.vector = {vector_base_register_q[7:3], `MFT_G_CMP};
      end
   end

   // read port, data one cycle after strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= `MFT_RST8;
      end else if (clk_en && reg_rd) begin
         case (reg_addr)
            `MFT_A_VECTOR:  rdata_q <= vector_base_register_q;
            `MFT_A_MASK:    rdata_q <= interrupt_dma_mask_register_q;
            `MFT_A_FLAG:    rdata_q <= timer_flag_register_q;
            `MFT_A_DMA_COUNTER_POINTER:    rdata_q <= dma_counter_pointer_q;
            `MFT_A_DMA_ADDRESS_POINTER:    rdata_q <= dma_address_pointer_q;
            `MFT_A_DCTL:    rdata_q <= dma_control_register_q;
            `MFT_A_CNT_CMP: rdata_q <= cnt_cmp_q[7:0];
            `MFT_A_CNT_CAP: rdata_q <= cnt_cap_q[7:0];
            `MFT_A_PEND:    rdata_q <= {3'h0, pend_q};
            default:        rdata_q <= `MFT_RST8;
         endcase
      end
   end
   assign reg_rdata = rdata_q;
endmodule

// [shared/mft_defs.svh]
// constants of the timer interrupt and dma request unit
`ifndef MFT_DEFS_SVH
`define MFT_DEFS_SVH
// Summary of operation
// - five sources in three groups: compares 110, captures 100, over/underflow 000
// - low three vector bits fixed by hardware per group; 000 is highest
// - upper five vector bits come from the software vector base register
// - each source has its mask bit; mask bit 7 globally enables interrupts
// - new compare-0/capture-0 request while pending sets that source's overrun flag
// - two dma channels: memory to compare-0, capture-0 to memory
// - with dma enabled, channel interrupt comes from end-of-block only
// - capture channel dma request outranks compare channel
// - dma mask gates requests; block irq mask gates end-of-block interrupts
// - upper five pointer bits shared by both channels, pointers mapped as pairs
// - transfer select 0: address bit 1 low for capture, high for compare
// - transfer select 1: one adjacent pointer pair, address pointer unused
// - word moves as two bytes; second byte forced to priority 000
// - counter reaching table end resets, flags end-of-block, stops block
// - swap mode toggles pointer bit 2 per end-of-block, software accessible
// - transfer address always uses serviced channel's own toggle bit
// - one swap enable bit applies to both channels
// - end-of-block irq at normal priority, only when no dma request active
// - software writing end-of-block flag 1 in swap mode raises interrupt
// - hardware end-of-block while flag still set clears channel dma mask

// register offsets on the plain port
`define MFT_A_VECTOR   4'h0
`define MFT_A_MASK     4'h1
`define MFT_A_FLAG     4'h2
`define MFT_A_DMA_COUNTER_POINTER     4'h3
`define MFT_A_DMA_ADDRESS_POINTER     4'h4
`define MFT_A_DCTL     4'h5
`define MFT_A_CNT_CMP  4'h6
`define MFT_A_CNT_CAP  4'h7
`define MFT_A_PEND     4'h8
// mask register fields
`define MFT_M_GLOBAL   7
`define MFT_M_CAP_DMA  6
`define MFT_M_CAP_IRQ  5
`define MFT_M_CMP_DMA  4
`define MFT_M_CMP_IRQ  3
`define MFT_M_CAP1     2
`define MFT_M_CMP1     1
`define MFT_M_OUF      0
// flag register fields
`define MFT_F_OVR_CMP  0
`define MFT_F_OVR_CAP  1
`define MFT_F_EOB_CMP  2
`define MFT_F_EOB_CAP  3
// pointer and dma control fields
`define MFT_P_XSEL     0
`define MFT_P_TOGGLE   2
`define MFT_C_SWAP     0
// hardware group codes, priority and register reset value
`define MFT_G_CMP      3'h6
`define MFT_G_CAP      3'h4
`define MFT_G_OUF      3'h0
`define MFT_PRIO_TOP   3'h0
`define MFT_RST8       8'h00
`endif

// [shared/mft_pkg.sv]
// types of the timer interrupt and dma request unit
package mft_pkg;
   typedef struct packed {
      logic       valid;
      logic [7:0] vector;
   } mft_irq_t;
   typedef struct packed {
      logic       valid;
      logic       to_compare;
      logic       second_byte;
      logic [2:0] prio_level;
      logic [7:0] counter_addr;
      logic [7:0] address_addr;
      logic       reg_to_reg;
   } mft_dma_req_t;
   typedef enum logic [1:0] {MFT_IDLE, MFT_BYTE1, MFT_BYTE2} mft_state_t;
endpackage

// [tb/mft_irq_dma_sva.sv]
// port assertions for the timer interrupt and dma request unit
`timescale 1ns/1ps
module mft_irq_dma_sva #(
   parameter int CNT_W = 16
) (
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire logic                  clk_en,
   input wire logic [3:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  compare_zero_event,
   input wire logic                  compare_one_event,
   input wire logic                  capture_zero_event,
   input wire logic                  capture_one_event,
   input wire logic                  over_underflow_event,
   input wire mft_pkg::mft_irq_t     irq_out,
   input wire logic                  irq_ack,
   input wire mft_pkg::mft_dma_req_t dma_req,
   input wire logic                  dma_byte_done
);
   import mft_pkg::*;
   logic [4:0] base_q;
   logic       glb_q;
   logic       evt;
   assign evt = capture_zero_event | compare_zero_event | dma_byte_done;
   // shadow of the software vector base and global enable
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         base_q <= 5'h00;
         glb_q  <= 1'b0;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == 4'h0) base_q <= reg_wdata[7:3];
         if (reg_addr == 4'h1) glb_q <= reg_wdata[7];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_group_code: assert property (
      irq_out.valid |-> irq_out.vector[2:0] inside {3'h6, 3'h4, 3'h0})
      else $error("vector low bits are no group code");
   a_vector_base: assert property (
      irq_out.valid |-> irq_out.vector[7:3] == base_q)
      else $error("vector upper bits differ from base");
   a_global_mask: assert property (
      irq_out.valid |-> glb_q)
      else $error("interrupt while globally masked");
   a_dma_start: assert property (
      $rose(dma_req.valid) |-> $past(evt) || $past(evt, 2))
      else $error("dma request without a cause");
   a_capture_first: assert property (
      capture_zero_event && compare_zero_event && !dma_req.valid
      |-> ##2 !(dma_req.valid && dma_req.to_compare))
      else $error("compare served before capture");
   a_second_prio: assert property (
      dma_req.valid && dma_req.second_byte |-> dma_req.prio_level == 3'h0)
      else $error("second byte not at top priority");
   a_word_hold: assert property (
      dma_req.valid && !(dma_byte_done && dma_req.second_byte)
      |=> dma_req.valid && $stable(dma_req.to_compare))
      else $error("word dropped or pre-empted");
   a_byte_step: assert property (
      clk_en && dma_req.valid && dma_byte_done && !dma_req.second_byte
      |=> dma_req.valid && dma_req.second_byte)
      else $error("second byte did not follow first");
   a_addr_split: assert property (
      dma_req.valid && !dma_req.reg_to_reg |-> dma_req.counter_addr[1] == dma_req.to_compare
      && dma_req.address_addr[1] == dma_req.to_compare)
      else $error("pointer bit 1 does not match channel");
endmodule
bind mft_irq_dma mft_irq_dma_sva #(.CNT_W(CNT_W)) sva_u (
   .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .compare_zero_event(compare_zero_event), .compare_one_event(compare_one_event),
   .capture_zero_event(capture_zero_event), .capture_one_event(capture_one_event),
   .over_underflow_event(over_underflow_event), .irq_out(irq_out), .irq_ack(irq_ack),
   .dma_req(dma_req), .dma_byte_done(dma_byte_done));

// [tb/mft_core_model.sv]
// core side model: dma controller pacing bytes, interrupt acknowledge
`timescale 1ns/1ps
module mft_core_model (
   input  wire mft_pkg::mft_dma_req_t dma_req,
   input  wire mft_pkg::mft_irq_t     irq_out,
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic [3:0]            stall,
   input  wire logic                  ack_en,
   output      logic                  dma_byte_done,
   output      logic                  irq_ack,
   output      logic [7:0]            words
);
   import mft_pkg::*;
   logic [3:0] wait_q;
   logic       done_q;
   logic       ack_q;
   logic [7:0] words_q;
   assign dma_byte_done = done_q;
   assign irq_ack = ack_q;
   assign words = words_q;
   // two bytes per word
   // a done never follows a done, so the design sees each byte apart
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wait_q  <= 4'h0;
         done_q  <= 1'b0;
         words_q <= 8'h00;
      end else begin
         done_q <= dma_req.valid && !done_q && wait_q >= stall;
         wait_q <= (dma_req.valid && !done_q && wait_q < stall) ? wait_q + 4'h1 : 4'h0;
         if (done_q && dma_req.second_byte) words_q <= words_q + 8'h01;
      end
   end
   // acknowledge only the top group, one pulse at a time
   always_ff @(posedge core_clk) begin
      ack_q <= rst_n && ack_en && !ack_q && irq_out.valid && irq_out.vector[2:0] == 3'h0;
   end
endmodule

// [tb/timer_interrupt_dma_unit_test.sv]
// self-checking bench for the timer interrupt and dma request unit
`timescale 1ns/1ps
module timer_interrupt_dma_unit_test;
   import mft_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         clk_en = 1'b1;
   logic [3:0]   reg_addr = 4'h0;
   logic [7:0]   reg_wdata = 8'h00;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [4:0]   ev = 5'h00;
   logic [3:0]   stall = 4'h0;
   logic         ack_en = 1'b0;
   logic [7:0]   reg_rdata;
   logic [7:0]   words;
   logic         irq_ack;
   logic         dma_byte_done;
   mft_irq_t     irq_out;
   mft_dma_req_t dma_req;
   int           failures = 0;
   int           comparisons = 0;
   mft_irq_dma #(.CNT_W(16)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .compare_zero_event(ev[0]), .compare_one_event(ev[1]), .capture_zero_event(ev[2]),
      .capture_one_event(ev[3]), .over_underflow_event(ev[4]), .irq_out(irq_out),
      .irq_ack(irq_ack), .dma_req(dma_req), .dma_byte_done(dma_byte_done));
   mft_core_model core_u (
      .dma_req(dma_req), .irq_out(irq_out), .core_clk(core_clk), .rst_n(rst_n),
      .stall(stall), .ack_en(ack_en), .dma_byte_done(dma_byte_done), .irq_ack(irq_ack),
      .words(words));
   task automatic tally_and_finish();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_irq(input logic v, input logic [7:0] vec);
      chk({7'h00, irq_out.valid}, {7'h00, v});
      if (v) chk(irq_out.vector, vec);
   endtask
   // one-cycle strobes, launched just after an edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge core_clk);
      ev <= m;
      @(posedge core_clk);
      ev <= 5'h00;
   endtask
   task automatic wait_words(input logic [7:0] n);
      for (int k = 0; k < 300 && words !== n; k++) @(posedge core_clk);
      #1 chk(words, n);
   endtask
   task automatic clr();
      wr(4'h2, 8'h00);
      wr(4'h8, 8'h1F);
   endtask
   task automatic s_regs();
      for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
      wr(4'hF, 8'h5A);
      rd(4'hF, 8'h00);
      // clock enable low must freeze the register file
      clk_en <= 1'b0;
      wr(4'h0, 8'hFF);
      clk_en <= 1'b1;
      rd(4'h0, 8'h00);
   endtask
   task automatic s_vector();
      logic [7:0] mb [5] = '{8'h08, 8'h02, 8'h20, 8'h04, 8'h01};
      logic [2:0] gc [5] = '{3'h6, 3'h6, 3'h4, 3'h4, 3'h0};
      wr(4'h0, 8'hA8);
      for (int i = 0; i < 5; i++) begin
         wr(4'h1, 8'h80 | mb[i]);
         pulse(5'h01 << i);
         #1 chk_irq(1'b1, {5'h15, gc[i]});
         wr(4'h1, mb[i]);
         #1 chk_irq(1'b0, 8'h00);
         wr(4'h1, 8'h80);
         #1 chk_irq(1'b0, 8'h00);
         wr(4'h1, 8'h80 | mb[i]);
         ack_en <= (i == 4);
         if (i < 4) wr(4'h8, 8'h01 << i);
         repeat (4) @(posedge core_clk);
         ack_en <= 1'b0;
         #1 chk_irq(1'b0, 8'h00);
      end
      wr(4'h1, 8'hA1);
      pulse(5'h14);
      #1 chk_irq(1'b1, 8'hA8);
      clr();
   endtask
   task automatic s_overrun();
      wr(4'h1, 8'hA8);
      pulse(5'h05);
      pulse(5'h05);
      rd(4'h2, 8'h03);
      clr();
   endtask
   task automatic s_dma(input logic ch, input logic [3:0] st);
      logic [7:0] w;
      stall <= st;
      wr(4'h3, {7'h22, ch});
      wr(4'h4, 8'h80);
      wr(4'h1, ch ? 8'h98 : 8'hE0);
      wr(ch ? 4'h6 : 4'h7, 8'h02);
      w = words;
      pulse(ch ? 5'h01 : 5'h04);
      @(posedge core_clk);
      #1 chk({7'h00, dma_req.valid}, 8'h01);
      chk({7'h00, dma_req.to_compare}, {7'h00, ch});
      chk({1'b0, dma_req.counter_addr[7:1]}, {6'h08, ch, ch});
      chk({1'b0, dma_req.address_addr[7:1]}, ch ? 8'h00 : {6'h10, ch, ch});
      chk({7'h00, dma_req.reg_to_reg}, {7'h00, ch});
      wait_words(w + 8'h01);
      chk({7'h00, irq_out.valid}, 8'h00);
      pulse(ch ? 5'h01 : 5'h04);
      wait_words(w + 8'h02);
      rd(4'h2, ch ? 8'h04 : 8'h08);
      rd(ch ? 4'h6 : 4'h7, 8'h00);
      chk_irq(1'b1, {5'h15, ch ? 3'h6 : 3'h4});
      clr();
   endtask
   task automatic s_both();
      logic [7:0] w;
      stall <= 4'h3;
      wr(4'h1, 8'h50);
      wr(4'h6, 8'h08);
      wr(4'h7, 8'h08);
      w = words;
      pulse(5'h05);
      @(posedge core_clk);
      #1 chk({7'h00, dma_req.to_compare}, 8'h00);
      wait_words(w + 8'h01);
      repeat (2) @(posedge core_clk);
      #1 chk({7'h00, dma_req.to_compare}, 8'h01);
      pulse(5'h04);
      #1 chk({7'h00, dma_req.to_compare}, 8'h01);
      wait_words(w + 8'h03);
      clr();
   endtask
   task automatic s_swap();
      logic [7:0] w;
      stall <= 4'h0;
      wr(4'h5, 8'h01);
      wr(4'h3, 8'h40);
      wr(4'h4, 8'h80);
      wr(4'h1, 8'hF8);
      wr(4'h6, 8'h01);
      w = words;
      pulse(5'h01);
      wait_words(w + 8'h01);
      rd(4'h3, 8'h44);
      wr(4'h7, 8'h01);
      pulse(5'h04);
      #1 chk_irq(1'b0, 8'h00);
      wait_words(w + 8'h02);
      rd(4'h4, 8'h84);
      wr(4'h7, 8'h01);
      pulse(5'h04);
      wait_words(w + 8'h03);
      rd(4'h1, 8'hB8);
      pulse(5'h04);
      @(posedge core_clk);
      #1 chk({7'h00, dma_req.valid}, 8'h00);
      wr(4'h4, 8'h80);
      rd(4'h2, 8'h0E);
      clr();
      wr(4'h1, 8'hF8);
      wr(4'h2, 8'h04);
      #1 chk_irq(1'b1, 8'hAE);
      clr();
      wr(4'h5, 8'h00);
   endtask
   // free-running core clock
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   // main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      s_regs();
      s_vector();
      s_overrun();
      s_dma(1'b0, 4'h0);
      s_dma(1'b1, 4'h5);
      s_both();
      s_swap();
      tally_and_finish();
   end
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end
endmodule
